//--- rtl/ssr_map.svh
/*
  Address map, field positions, reset values and fixed codes of the slot
  status, indirect configuration window and serial number register bank.
  Assumes a 12-bit APB byte address and 32-bit data words.
*/
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// ***************************************************************************
// Register byte offsets
// ***************************************************************************
`define SSR_AW 12
`define SSR_OFF_SLOT 12'h080
`define SSR_OFF_CFGA 12'h0F8
`define SSR_OFF_CFGD 12'h0FC
`define SSR_OFF_SNCAP 12'h100
`define SSR_OFF_SNLO 12'h104
`define SSR_OFF_SNHI 12'h108

// ***************************************************************************
// Slot status and control fields
// ***************************************************************************
`define SSR_EN_RANGE 5:0
`define SSR_EN_GLOBAL 5
`define SSR_EN_EVENTS 4:0
`define SSR_ST_RANGE 20:16
`define SSR_ST_LATCH 21
`define SSR_ST_PRES 22
`define SSR_EV_N 5
`define SSR_LANE_EN 0
`define SSR_LANE_ST 2
`define SSR_EN_RST 6'h00
`define SSR_EV_RST 5'h00

// ***************************************************************************
// Indirect configuration address window fields
// ***************************************************************************
`define SSR_CFGA_FUNC 2:0
`define SSR_CFGA_DEV 7:3
`define SSR_CFGA_BUS 15:8
`define SSR_CFGA_DWORD 25:16
`define SSR_CFGA_RSVD 30:26
`define SSR_CFGA_EN 31
`define SSR_CFGA_MASK 32'h83FF_FFFF

// ***************************************************************************
// Serial number capability and common values
// ***************************************************************************
`define SSR_CAP_ID 16'h0003
`define SSR_CAP_VER 4'h1
`define SSR_CAP_NEXT 12'hFB4
`define SSR_SN_LO 31:0
`define SSR_SN_HI 63:32
`define SSR_ZERO32 32'h0000_0000
`define SSR_LANES 4
`define SSR_LANE_W 8

`endif

//--- rtl/ssr_pkg.sv
/*
  Types shared by the slot status register bank: slot sense inputs, the
  indirect configuration request and the bus state encoding.
  Assumes the constants of ssr_map.svh are included by the user.
*/
package ssr_pkg;

  typedef struct packed {
    logic attn_button;
    logic power_fault;
    logic latch_open;
    logic card_present;
    logic cmd_done;
  } ssr_slot_in_t;

  typedef struct packed {
    logic write;
    logic [2:0] func;
    logic [4:0] dev;
    logic [7:0] bus;
    logic [9:0] dword;
    logic [31:0] wdata;
  } ssr_icfg_req_t;

  typedef enum logic [2:0] {
    SSR_IDLE = 3'h1,
    SSR_WAIT = 3'h2,
    SSR_RESP = 3'h4
  } ssr_bus_state_t;

endpackage : ssr_pkg

//--- rtl/ssr_regs.sv
/*
  APB register bank holding slot status with hot-plug interrupt enables,
  the indirect configuration address and data windows, and the serial
  number capability. Assumes synchronous slot inputs, an indirect access
  engine that answers each request with icfg_ack, and an APB master.
*/
// The APB interface to the registers was chosen for this implementation.
// Overview of operation
// RULE1 - Reverse mode: attention button press sets sticky bit 16, write one clears.
// RULE2 - Reverse mode: slot power fault sets sticky bit 17, write one clears.
// RULE3 - Reverse mode: retention latch change sets sticky bit 18, write one clears.
// RULE4 - Reverse mode: presence change sets sticky bit 19, write one clears.
// RULE5 - Reverse mode: hot-plug command completion sets sticky bit 20, write one clears.
// RULE6 - Bit 21 shows live latch state, one means open.
// RULE7 - Bit 22 shows live presence, one means card present.
// RULE8 - Forward mode: event bits read-only and inert; status bits 16 to 20 reset zero, bits 21 and 22 stay live.
// RULE9 - Address window holds function, device, bus, dword index and enable; reset zero.
// RULE10 - Data window reads or writes the register selected by the address window.
// RULE11 - Capability header reads ID 0003h, version 1h, next pointer FB4h.
// RULE12 - Serial number is 64 read-only bits, low then high dword, loadable.
// RULE13 - Interrupt needs event enable and global enable bit 5 both set.
// RULE14 - Reserved bits read zero and ignore writes.
// RULE15 - Forward mode: both window registers are read-only.
`timescale 1ns/10ps
`include "ssr_map.svh"

module ssr_regs
  import ssr_pkg::*;
#(
  // Value is arbitrary.
  parameter logic [63:0] SN_DEFAULT = 64'h0123_4567_89AB_CDEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SSR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rev_mode,
  input wire ssr_slot_in_t slot_i,
  input wire logic sn_load,
  input wire logic [63:0] sn_load_value,
  output logic icfg_valid,
  output ssr_icfg_req_t icfg_req,
  input wire logic icfg_ack,
  input wire logic [31:0] icfg_rdata,
  output logic hp_irq
);

  // *************************************************************************
  // Declarations
  // *************************************************************************
  ssr_bus_state_t bst_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [`SSR_EV_N-1:0] ev_q;
  logic [`SSR_EV_N-1:0] ev_set;
  logic [`SSR_EV_N-1:0] ev_clr;
  logic [5:0] en_q;
  logic [31:0] addr_q;
  logic [31:0] data_q;
  logic [63:0] sn_q;
  ssr_icfg_req_t req_q;
  ssr_slot_in_t prev_q;
  logic armed_q;
  logic irq_q;
  logic [31:0] rd_data;
  logic rd_err;
  logic setup;
  logic is_ind;
  logic wr_fire;
  logic [31:0] cap_hdr;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < `SSR_LANES; i++) begin
      if (strb[i]) begin
        r[i*`SSR_LANE_W +: `SSR_LANE_W] = new_v[i*`SSR_LANE_W +: `SSR_LANE_W];
      end
    end
    return r;
  endfunction : lane_merge

  assign cap_hdr = {`SSR_CAP_NEXT, `SSR_CAP_VER, `SSR_CAP_ID}; // [RULE11]
  assign setup = psel && !penable && (bst_q == SSR_IDLE);
  assign is_ind = rev_mode && (paddr == `SSR_OFF_CFGD) && addr_q[`SSR_CFGA_EN]; // [RULE10]
  assign wr_fire = psel && penable && pwrite && (bst_q == SSR_RESP);

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pready = (bst_q == SSR_RESP);
  assign icfg_valid = (bst_q == SSR_WAIT);
  assign icfg_req = req_q;
  assign hp_irq = irq_q;

  // *************************************************************************
  // Read decode
  // *************************************************************************
  always_comb begin
    rd_data = `SSR_ZERO32;
    rd_err = 1'b0;
    if (paddr == `SSR_OFF_SLOT) begin
      rd_data[`SSR_EN_RANGE] = en_q;
      rd_data[`SSR_ST_RANGE] = ev_q;
      rd_data[`SSR_ST_LATCH] = slot_i.latch_open; // [RULE6]
      rd_data[`SSR_ST_PRES] = slot_i.card_present; // [RULE7]
    end else if (paddr == `SSR_OFF_CFGA) begin
      rd_data = addr_q & `SSR_CFGA_MASK; // [RULE14]
    end else if (paddr == `SSR_OFF_CFGD) begin
      rd_data = data_q;
    end else if (paddr == `SSR_OFF_SNCAP) begin
      rd_data = cap_hdr;
    end else if (paddr == `SSR_OFF_SNLO) begin
      rd_data = sn_q[`SSR_SN_LO]; // [RULE12]
    end else if (paddr == `SSR_OFF_SNHI) begin
      rd_data = sn_q[`SSR_SN_HI]; // [RULE12]
    end else begin
      rd_err = 1'b1;
    end
  end

  // *************************************************************************
  // APB transfer sequencing
  // *************************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bst_q <= SSR_IDLE;
    end else begin
      case (bst_q)
        SSR_IDLE: begin
          if (psel && !penable) begin
            bst_q <= is_ind ? SSR_WAIT : SSR_RESP;
          end
        end
        SSR_WAIT: begin
          if (icfg_ack) begin
            bst_q <= SSR_RESP;
          end
        end
        SSR_RESP: begin
          if (psel && penable) begin
            bst_q <= SSR_IDLE;
          end
        end
        default: begin
          bst_q <= SSR_IDLE;
        end
      endcase
    end
  end

  // A direct answer is registered at setup, so pready may rise in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `SSR_ZERO32;
      pslverr_q <= 1'b0;
    end else if (setup && !is_ind) begin
      prdata_q <= pwrite ? `SSR_ZERO32 : rd_data;
      pslverr_q <= rd_err;
    end else if ((bst_q == SSR_WAIT) && icfg_ack) begin
      prdata_q <= pwrite ? `SSR_ZERO32 : icfg_rdata; // [RULE10]
      pslverr_q <= 1'b0;
    end
  end

  // *************************************************************************
  // Indirect configuration request
  // *************************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= '0;
    end else if (setup && is_ind) begin
      req_q.write <= pwrite; // [RULE10]
      req_q.func <= addr_q[`SSR_CFGA_FUNC];
      req_q.dev <= addr_q[`SSR_CFGA_DEV];
      req_q.bus <= addr_q[`SSR_CFGA_BUS];
      req_q.dword <= addr_q[`SSR_CFGA_DWORD];
      req_q.wdata <= lane_merge(data_q, pwdata, pstrb);
    end
  end

  // *************************************************************************
  // Address and data windows
  // *************************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= `SSR_ZERO32; // [RULE9]
    end else if (wr_fire && rev_mode && (paddr == `SSR_OFF_CFGA)) begin // [RULE15]
      addr_q <= lane_merge(addr_q, pwdata, pstrb) & `SSR_CFGA_MASK; // [RULE14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= `SSR_ZERO32;
    end else if ((bst_q == SSR_WAIT) && icfg_ack && !req_q.write) begin
      data_q <= icfg_rdata; // [RULE10]
    end else if (wr_fire && rev_mode && (paddr == `SSR_OFF_CFGD)) begin // [RULE15]
      data_q <= lane_merge(data_q, pwdata, pstrb);
    end
  end

  // *************************************************************************
  // Serial number
  // *************************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sn_q <= SN_DEFAULT;
    end else if (sn_load) begin
      sn_q <= sn_load_value; // [RULE12]
    end
  end

  // *************************************************************************
  // Slot events and enables
  // *************************************************************************
  // The first cycle after reset only samples the inputs, so a card already present
  // at reset does not look like a change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q <= slot_i;
      armed_q <= 1'b1;
    end
  end

  always_comb begin
    ev_set = `SSR_EV_RST;
    ev_set[0] = slot_i.attn_button && !prev_q.attn_button; // [RULE1]
    ev_set[1] = slot_i.power_fault && !prev_q.power_fault; // [RULE2]
    ev_set[2] = slot_i.latch_open != prev_q.latch_open; // [RULE3]
    ev_set[3] = slot_i.card_present != prev_q.card_present; // [RULE4]
    ev_set[4] = slot_i.cmd_done; // [RULE5]
    if (!armed_q || !rev_mode) begin
      ev_set = `SSR_EV_RST; // [RULE8]
    end
  end

  assign ev_clr = (wr_fire && rev_mode && (paddr == `SSR_OFF_SLOT) && pstrb[`SSR_LANE_ST]) ?
                  pwdata[`SSR_ST_RANGE] : `SSR_EV_RST;

  // A new event wins over a clear in the same cycle.
  for (genvar g = 0; g < `SSR_EV_N; g++) begin : g_ev
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ev_q[g] <= 1'b0; // [RULE8]
      end else if (!rev_mode) begin
        ev_q[g] <= 1'b0; // [RULE8]
      end else if (ev_set[g]) begin
        ev_q[g] <= 1'b1; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
      end else if (ev_clr[g]) begin
        ev_q[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= `SSR_EN_RST;
    end else if (!rev_mode) begin
      en_q <= `SSR_EN_RST;
    end else if (wr_fire && (paddr == `SSR_OFF_SLOT) && pstrb[`SSR_LANE_EN]) begin
      en_q <= pwdata[`SSR_EN_RANGE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= rev_mode && en_q[`SSR_EN_GLOBAL] && (|(ev_q & en_q[`SSR_EN_EVENTS])); // [RULE13]
    end
  end

  // *************************************************************************
  // Assertions
  // *************************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup(logic [`SSR_AW-1:0] a, logic w);
    setup && (paddr == a) && (pwrite == w);
  endsequence

  sequence s_ind_ack;
    icfg_valid && icfg_ack && !icfg_req.write;
  endsequence

  a_attn_sets: assert property ( // [RULE1]
    rev_mode && armed_q && slot_i.attn_button && !prev_q.attn_button ##1 rev_mode |-> ev_q[0])
    else $error("attention press did not set its status bit");

  a_fault_sets: assert property ( // [RULE2]
    rev_mode && armed_q && $rose(slot_i.power_fault) ##1 rev_mode |-> ev_q[1])
    else $error("power fault did not set its status bit");

  a_latch_sets: assert property ( // [RULE3]
    rev_mode && armed_q && (slot_i.latch_open != prev_q.latch_open) ##1 rev_mode |-> ev_q[2])
    else $error("latch change did not set its status bit");

  a_pres_sets: assert property ( // [RULE4]
    rev_mode && armed_q && $changed(slot_i.card_present) ##1 rev_mode |-> ev_q[3])
    else $error("presence change did not set its status bit");

  a_cmd_sets: assert property ( // [RULE5]
    rev_mode && armed_q && slot_i.cmd_done ##1 rev_mode |-> ev_q[4])
    else $error("command completion did not set its status bit");

  a_w1c_clear: assert property ( // [RULE1]
    ev_q[0] && ev_clr[0] && !ev_set[0] |=> !ev_q[0])
    else $error("write one did not clear the attention bit");

  a_live_bits: assert property ( // [RULE6]
    s_setup(`SSR_OFF_SLOT, 1'b0) |=> pready && (prdata[`SSR_ST_LATCH] == $past(slot_i.latch_open))
      && (prdata[`SSR_ST_PRES] == $past(slot_i.card_present)))
    else $error("live slot state bits read wrong");

  a_fwd_quiet: assert property ( // [RULE8]
    !rev_mode |=> (ev_q == `SSR_EV_RST) && !hp_irq)
    else $error("status bits active in forward mode");

  a_addr_rsvd: assert property ( // [RULE14]
    addr_q[`SSR_CFGA_RSVD] == 5'h00)
    else $error("address window reserved bits set");

  a_addr_write: assert property ( // [RULE9]
    wr_fire && rev_mode && (paddr == `SSR_OFF_CFGA) && (pstrb == 4'hF)
      |=> addr_q == ($past(pwdata) & `SSR_CFGA_MASK))
    else $error("address window did not store its fields");

  a_fwd_ro: assert property ( // [RULE15]
    wr_fire && !rev_mode |=> $stable(addr_q) && $stable(data_q))
    else $error("window written in forward mode");

  a_ind_request: assert property ( // [RULE10]
    setup && is_ind |=> icfg_valid && (icfg_req.dword == $past(addr_q[`SSR_CFGA_DWORD])))
    else $error("indirect request missing or wrong target");

  a_ind_answer: assert property ( // [RULE10]
    s_ind_ack |=> pready && (prdata == $past(icfg_rdata)))
    else $error("indirect read data not returned");

  a_cap_header: assert property ( // [RULE11]
    s_setup(`SSR_OFF_SNCAP, 1'b0) |=> pready && (prdata == 32'hFB41_0003))
    else $error("capability header reads wrong");

  a_sn_split: assert property ( // [RULE12]
    s_setup(`SSR_OFF_SNHI, 1'b0) && !sn_load |=> prdata == sn_q[`SSR_SN_HI])
    else $error("serial number high dword reads wrong");

  a_irq_gate: assert property ( // [RULE13]
    hp_irq |-> $past(en_q[`SSR_EN_GLOBAL]) && $past(|(ev_q & en_q[`SSR_EN_EVENTS])))
    else $error("interrupt raised without enables");

  a_cmd_clear: assert property ( // [RULE5]
    ev_q[4] && ev_clr[4] && !ev_set[4] |=> !ev_q[4])
    else $error("write one did not clear the command completion bit");

  a_irq_raise: assert property ( // [RULE13]
    rev_mode && en_q[`SSR_EN_GLOBAL] && (|(ev_q & en_q[`SSR_EN_EVENTS])) |=> hp_irq)
    else $error("enabled event did not raise the interrupt");

  a_ready_pulse: assert property ( // [RULE10]
    pready && psel && penable |=> !pready)
    else $error("ready held beyond one access cycle");

endmodule : ssr_regs

//--- tb/ssr_tb.sv
/*
  Self-checking bench for the slot status, indirect window and serial
  number register bank. Assumes ssr_map.svh and ssr_pkg are compiled first.
*/
`timescale 1ns/10ps
`include "ssr_map.svh"
module testbench
  import ssr_pkg::*;
;
  // Value is arbitrary.
  localparam logic [63:0] SN_V = 64'hA5A5_1234_5A5A_9876;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rev_mode;
  logic sn_load, icfg_valid, icfg_ack, hp_irq, er;
  logic [`SSR_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, icfg_rdata, rd;
  logic [3:0] pstrb;
  logic [63:0] sn_v;
  ssr_slot_in_t slot_i;
  ssr_icfg_req_t icfg_req, lq;
  int err_total, n_compared, ac;

  ssr_regs #(.SN_DEFAULT(SN_V)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rev_mode(rev_mode),
    .slot_i(slot_i), .sn_load(sn_load), .sn_load_value(sn_v), .icfg_valid(icfg_valid),
    .icfg_req(icfg_req), .icfg_ack(icfg_ack), .icfg_rdata(icfg_rdata), .hp_irq(hp_irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****
  // Indirect access engine stand-in
  // ****
  // Answers each request in the fourth cycle of icfg_valid.
  always @(posedge pclk) begin
    if (icfg_valid === 1'b1 && icfg_ack !== 1'b1) begin
      ac <= ac + 1;
      if (ac == 2) begin
        icfg_ack <= 1'b1;
        icfg_rdata <= 32'hBEEF_0000 ^ {22'h0, icfg_req.dword};
        lq <= icfg_req;
      end
    end else begin
      ac <= 0;
      icfg_ack <= 1'b0;
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Pready, read data and error are taken at the rising edge that completes the transfer.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 60);
    if (pready !== 1'b1) begin
      err_total++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(rd, e);
  endtask : rc

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bus(1'b1, a, d, s);
  endtask : wr

  task automatic sl(input logic [4:0] v);
    @(posedge pclk);
    slot_i <= v;
  endtask : sl

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : cyc

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rc(12'h080, 32'h0);
    rc(12'h0F8, 32'h0);
    rc(12'h0FC, 32'h0);
    rc(12'h100, 32'hFB41_0003);
    rc(12'h104, SN_V[31:0]);
    rc(12'h108, SN_V[63:32]);
    $display("test reset done");
  endtask : t_reset

  task automatic t_events;
    logic [4:0] v;
    logic [31:0] lv;
    v = 5'h0;
    for (int k = 0; k < 5; k++) begin
      v[4-k] = 1'b1;
      sl(v);
      if (k == 4) begin
        v[0] = 1'b0;
        sl(v);
      end
      lv = {9'h0, v[1], v[2], 21'h0};
      rc(12'h080, lv | (32'h1 << (16 + k)));
      wr(12'h080, 32'h1 << (16 + k), 4'h4);
      rc(12'h080, lv);
    end
    v[2] = 1'b0;
    sl(v);
    rc(12'h080, 32'h0044_0000);
    wr(12'h080, 32'h0004_0000, 4'h4);
    rc(12'h080, 32'h0040_0000);
    $display("test events done");
  endtask : t_events

  task automatic t_irq;
    sl(5'h0);
    wr(12'h080, 32'h001F_0000, 4'h4);
    wr(12'h080, 32'h0000_0001, 4'h1);
    sl(5'h10);
    cyc(3);
    chk({31'h0, hp_irq}, 32'h0);
    wr(12'h080, 32'h0000_0021, 4'h1);
    cyc(2);
    chk({31'h0, hp_irq}, 32'h1);
    sl(5'h18);
    wr(12'h080, 32'h0001_0000, 4'h4);
    cyc(2);
    chk({31'h0, hp_irq}, 32'h0);
    wr(12'h080, 32'hFF80_FFFF, 4'hF);
    rc(12'h080, 32'h0002_003F);
    chk({31'h0, hp_irq}, 32'h1);
    $display("test irq done");
  endtask : t_irq

  task automatic t_cfg;
    wr(12'h0F8, 32'hFFFF_FFFF, 4'hF);
    rc(12'h0F8, 32'h83FF_FFFF);
    wr(12'h0F8, 32'h82A5_3CDD, 4'hF);
    rc(12'h0FC, 32'hBEEF_02A5);
    chk({5'h0, lq.write, lq.func, lq.dev, lq.bus, lq.dword},
        {5'h0, 1'b0, 3'h5, 5'h1B, 8'h3C, 10'h2A5});
    wr(12'h0FC, 32'h1357_9BDF, 4'hF);
    chk(lq.wdata, 32'h1357_9BDF);
    chk({31'h0, lq.write}, 32'h1);
    wr(12'h0F8, 32'h0, 4'hF);
    wr(12'h0FC, 32'h2468_ACE0, 4'hF);
    rc(12'h0FC, 32'h2468_ACE0);
    $display("test cfg done");
  endtask : t_cfg

  task automatic t_misc;
    bus(1'b0, 12'h0F0, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    @(posedge pclk);
    sn_v <= 64'h0F1E_2D3C_4B5A_6978;
    sn_load <= 1'b1;
    @(posedge pclk);
    sn_load <= 1'b0;
    wr(12'h104, 32'hFFFF_FFFF, 4'hF);
    rc(12'h104, 32'h4B5A_6978);
    rc(12'h108, 32'h0F1E_2D3C);
    rc(12'h100, 32'hFB41_0003);
    $display("test misc done");
  endtask : t_misc

  task automatic t_fwd;
    @(posedge pclk);
    rev_mode <= 1'b0;
    wr(12'h0F8, 32'h8000_0001, 4'hF);
    wr(12'h0FC, 32'hFFFF_FFFF, 4'hF);
    rc(12'h0F8, 32'h0);
    rc(12'h0FC, 32'h2468_ACE0);
    wr(12'h080, 32'h0000_003F, 4'h1);
    sl(5'h17);
    sl(5'h16);
    rc(12'h080, 32'h0060_0000);
    chk({31'h0, hp_irq}, 32'h0);
    $display("test fwd done");
  endtask : t_fwd

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    rev_mode = 1'b1;
    slot_i = '0;
    sn_load = 1'b0;
    sn_v = 64'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_irq();
    t_cfg();
    t_misc();
    t_fwd();
    test_done();
  end
endmodule : testbench
